//--- inc/cmau_consts.vh
`ifndef CMAU_CONSTS_VH
`define CMAU_CONSTS_VH

// Per-bit-cell line symbols on the decoded circuits
`define CMAU_SYM_IDL 2'h0
`define CMAU_SYM_CD0 2'h1
`define CMAU_SYM_CD1 2'h2
`define CMAU_SYM_CSO 2'h3

// Register byte addresses (word aligned)
`define CMAU_ADR_CTRL 4'h0
`define CMAU_ADR_STAT 4'h4
`define CMAU_ADR_COLCNT 4'h8
`define CMAU_ADR_FRMCNT 4'hc

// Control register fields and reset value
`define CMAU_CTRL_ISO 0
`define CMAU_CTRL_SQET 1
`define CMAU_CTRL_RST 2'h2

// Status register fields
`define CMAU_STAT_COL 0
`define CMAU_STAT_JAB 1
`define CMAU_STAT_ISO 2
`define CMAU_STAT_TX 3
`define CMAU_STAT_TEST 4
`define CMAU_STAT_DRV 5

// System clock and bit-rate divider (25 MHz to 10 Mb/s by 2,3,2,3)
`define CMAU_CLK_MHZ 25
`define CMAU_DIV_SHORT 2'h1
`define CMAU_DIV_LONG 2'h2

// Post-frame test sequence timing
`define CMAU_SQE_DLY_MIN_NS 600
`define CMAU_SQE_DLY_MAX_NS 1600
`define CMAU_SQE_DLY_CYC ((`CMAU_SQE_DLY_MIN_NS * `CMAU_CLK_MHZ + 999) / 1000)
`define CMAU_SQE_TEST_BITS 4'ha

// Jabber window and self-powered release period
`define CMAU_JAB_MIN_MS 20
`define CMAU_JAB_MAX_MS 150
`define CMAU_UNJAB_MS 500
`define CMAU_MS_CYC (`CMAU_CLK_MHZ * 1000)
`define CMAU_JAB_CYC (`CMAU_JAB_MIN_MS * `CMAU_MS_CYC)
`define CMAU_UNJAB_CYC (`CMAU_UNJAB_MS * `CMAU_MS_CYC)

`endif

//--- core/cmau_bitclk.v
`timescale 1ns/1ps
`include "cmau_consts.vh"

module cmau_bitclk (
   input wire clock,
   input wire rst,
   output reg bit_en_r
);

   reg [1:0] cnt_r;
   reg long_r;

   // Alternate 2 and 3 cycle cells so the average is exactly the bit rate
   always @(posedge clock) begin
      if (rst) begin
         cnt_r <= 2'h0;
         long_r <= 1'b0;
         bit_en_r <= 1'b0;
      end else if (cnt_r == (long_r ? `CMAU_DIV_LONG : `CMAU_DIV_SHORT)) begin
         cnt_r <= 2'h0;
         long_r <= ~long_r;
         bit_en_r <= 1'b1;
      end else begin
         cnt_r <= cnt_r + 2'h1;
         bit_en_r <= 1'b0;
      end
   end

endmodule

//--- core/cmau_jabber.v
`timescale 1ns/1ps
`include "cmau_consts.vh"

module cmau_jabber #(
   parameter [23:0] JAB_CYC = 24'h07a120,
   parameter [23:0] UNJAB_CYC = 24'hbebc20
) (
   input wire clock,
   input wire rst,
   input wire tx_active,
   input wire iso_en,
   input wire iso_req,
   output reg jab_r
);

   reg [23:0] cnt_r;

   // One counter: frame length while clear, release time while inhibited
   always @(posedge clock) begin
      if (rst) begin
         cnt_r <= 24'h000000;
         jab_r <= 1'b0;
      end else if (!jab_r) begin
         if (!tx_active) begin
            cnt_r <= 24'h000000;
         end else if (cnt_r == JAB_CYC - 24'h000001) begin
            cnt_r <= 24'h000000;
            jab_r <= 1'b1;
         end else begin
            cnt_r <= cnt_r + 24'h000001;
         end
      end else if (iso_en) begin
         // With isolate support only the isolate message releases the inhibit
         cnt_r <= 24'h000000;
         if (iso_req) begin
            jab_r <= 1'b0;
         end
      end else if (cnt_r == UNJAB_CYC - 24'h000001) begin
         cnt_r <= 24'h000000;
         jab_r <= 1'b0;
      end else begin
         cnt_r <= cnt_r + 24'h000001;
      end
   end

endmodule

//--- core/cmau_top.v
`timescale 1ns/1ps
`include "cmau_consts.vh"
// Summary of operation
// - Forward each received bit as CD0 for zero, CD1 for one on data-in.
// - Receive symbols pass through without re-timing to the local bit clock.
// - Data-in shows IDL whenever no received data is present.
// - Control-in shows IDL continuously unless signal quality error is sent.
// - IDL on control-out keeps the transmitter nonintrusive, not positively disabled.
// - CSO on control-out, when isolate supported, positively disables the transmitter.
// - No error indication with zero or one station transmitting.
// - Not transmitting: indicate whenever two remote stations are detected.
// - Transmitting: any other transmitter causes an error indication.
// - After each output frame run a short signal quality test.
// - Indicate error for the whole time jabber inhibits the transmitter.
// - Assert under 9 bit cells after collision, remove within 20.
// - Error indication is CSO on the control-in circuit.
// - Error indication works whenever powered, not only during output.
// - Positive disable and release actions drive a dedicated disable output.
// - Enable and disable driver actions gate the normal transmit path.
// - Collision indication true when multiple transmitters active, else false; here collision_r also goes true during the post-frame test and jabber.
// - Test starts 0.6 to 1.6 us after idle, lasts 10 bit cells.
// - Jabber inhibits output after a 20 to 150 ms window.
// - CSO is a bit-rate periodic symbol stream within tolerance and duty.
// - Isolate never affects receive data or collision reporting; here isolate support makes jabber wait for the isolate message.

module cmau_top #(
   parameter [23:0] JAB_CYC = `CMAU_JAB_CYC,
   parameter [23:0] UNJAB_CYC = `CMAU_UNJAB_CYC
) (
   input wire clock,
   input wire rst,
   input wire wb_cyc_i,
   input wire wb_stb_i,
   input wire wb_we_i,
   input wire [3:0] wb_adr_i,
   input wire [3:0] wb_sel_i,
   input wire [31:0] wb_dat_i,
   output reg [31:0] wb_dat_o,
   output reg wb_ack_o,
   input wire [1:0] do_sym,
   input wire [1:0] co_sym,
   output reg [1:0] di_sym_r,
   output reg [1:0] ci_sym_r,
   input wire [1:0] rx_sym,
   input wire medium_multi,
   output reg [1:0] tx_sym_r,
   output reg drv_en_r,
   output reg pos_dis_r,
   output reg collision_r
);

   localparam [1:0] ST_IDLE = 2'h0;
   localparam [1:0] ST_WAIT = 2'h1;
   localparam [1:0] ST_TEST = 2'h2;
   // Delay in clocks, cut to the counter width on purpose; it is far below 64
   localparam [31:0] SQE_DLY_FULL = `CMAU_SQE_DLY_CYC;
   localparam [5:0] SQE_DLY = SQE_DLY_FULL[5:0];

   // True for a data symbol on any circuit
   function is_data;
      input [1:0] s;
      begin
         is_data = (s == `CMAU_SYM_CD0) || (s == `CMAU_SYM_CD1);
      end
   endfunction

   // Exact byte-address match; unmapped addresses decode to nothing
   function adr_is;
      input [3:0] adr;
      input [3:0] want;
      begin
         adr_is = (adr == want);
      end
   endfunction

   // Event counter step; an event in the clearing cycle leaves a count of one
   function [15:0] cnt_step;
      input [15:0] cnt;
      input evt;
      input clr;
      begin
         if (evt) begin
            cnt_step = clr ? 16'h0001 : cnt + 16'h0001;
         end else if (clr) begin
            cnt_step = 16'h0000;
         end else begin
            cnt_step = cnt;
         end
      end
   endfunction

   // Strobe and inhibit flag from the two helper blocks
   wire bit_en;
   wire jab;

   // Control register and DTE circuits as seen at the last bit cell
   reg [1:0] ctrl_r;
   reg [1:0] do_q_r;
   reg [1:0] co_q_r;
   reg tx_prev_r;

   // Isolate, post-frame test and event counting state
   reg isolated_r;
   reg [1:0] st_r;
   reg [1:0] st_nxt;
   reg [5:0] dly_r;
   reg [3:0] bits_r;
   reg col_prev_r;
   reg [15:0] colcnt_r;
   reg [15:0] frmcnt_r;

   // Read word, combinational here and registered onto the bus below
   reg [31:0] rdata;

   // Link decode: what the DTE sends and what the medium driver may do
   wire tx_now = is_data(do_q_r);
   wire iso_req = ctrl_r[`CMAU_CTRL_ISO] && (co_q_r == `CMAU_SYM_CSO);
   wire frame_end = bit_en && tx_prev_r && !tx_now;
   wire test_on = (st_r == ST_TEST);
   wire drv_ok = tx_now && !jab && !isolated_r;
   wire col_now = medium_multi || test_on || jab;

   // Register bus decode; a request is taken once, while ack is still low
   wire wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
   wire wb_wr = wb_req && wb_we_i;
   wire wr_ctrl = wb_wr && adr_is(wb_adr_i, `CMAU_ADR_CTRL) && wb_sel_i[0];
   wire wr_colcnt = wb_wr && adr_is(wb_adr_i, `CMAU_ADR_COLCNT);
   wire wr_frmcnt = wb_wr && adr_is(wb_adr_i, `CMAU_ADR_FRMCNT);

   // Counter next values; a clear write never swallows a same-cycle event
   wire col_rise = collision_r && !col_prev_r;
   wire [15:0] colcnt_nxt = cnt_step(colcnt_r, col_rise, wr_colcnt);
   wire [15:0] frmcnt_nxt = cnt_step(frmcnt_r, frame_end, wr_frmcnt);

   cmau_bitclk u_bitclk (
      .clock(clock),
      .rst(rst),
      .bit_en_r(bit_en)
   );

   cmau_jabber #(
      .JAB_CYC(JAB_CYC),
      .UNJAB_CYC(UNJAB_CYC)
   ) u_jabber (
      .clock(clock),
      .rst(rst),
      .tx_active(tx_now),
      .iso_en(ctrl_r[`CMAU_CTRL_ISO]),
      .iso_req(iso_req),
      .jab_r(jab)
   );

   // DTE circuits are sampled once per bit cell as decoded symbols
   // A symbol shorter than a bit cell may fall between two strobes and be lost
   always @(posedge clock) begin
      if (rst) begin
         do_q_r <= `CMAU_SYM_IDL;
         co_q_r <= `CMAU_SYM_IDL;
         tx_prev_r <= 1'b0;
      end else if (bit_en) begin
         do_q_r <= do_sym;
         co_q_r <= co_sym;
         tx_prev_r <= tx_now;
      end
   end

   // Isolate state follows the control-out message; ignored when unsupported
   // Only IDL clears it: a data symbol on control-out is no normal message
   always @(posedge clock) begin
      if (rst) begin
         isolated_r <= 1'b0;
      end else if (!ctrl_r[`CMAU_CTRL_ISO]) begin
         isolated_r <= 1'b0;
      end else if (bit_en) begin
         if (co_q_r == `CMAU_SYM_CSO) begin
            isolated_r <= 1'b1;
         end else if (co_q_r == `CMAU_SYM_IDL) begin
            isolated_r <= 1'b0;
         end
      end
   end

   // Medium driver: normal path and dedicated positive disable
   // Either means alone keeps the medium quiet, so a stuck gate is covered
   always @(posedge clock) begin
      if (rst) begin
         drv_en_r <= 1'b0;
         pos_dis_r <= 1'b0;
         tx_sym_r <= `CMAU_SYM_IDL;
      end else begin
         drv_en_r <= drv_ok;
         pos_dis_r <= isolated_r || jab;
         tx_sym_r <= drv_ok ? do_q_r : `CMAU_SYM_IDL;
      end
   end

   // Receive data goes straight through each clock, never held to bit_en,
   // so the edge position toward the DTE is not quantised to local cells
   always @(posedge clock) begin
      if (rst) begin
         di_sym_r <= `CMAU_SYM_IDL;
      end else begin
         di_sym_r <= rx_sym;
      end
   end

   // Post-frame test sequence state register
   always @(posedge clock) begin
      if (rst) begin
         st_r <= ST_IDLE;
      end else begin
         st_r <= st_nxt;
      end
   end

   // Wait at least the minimum delay after idle, then hold for ten cells
   always @* begin
      st_nxt = st_r;
      case (st_r)
         ST_IDLE: begin
            if (frame_end && ctrl_r[`CMAU_CTRL_SQET]) begin
               st_nxt = ST_WAIT;
            end
         end
         ST_WAIT: begin
            if (dly_r == SQE_DLY - 6'h01) begin
               st_nxt = ST_TEST;
            end
         end
         ST_TEST: begin
            if (bit_en && bits_r == `CMAU_SQE_TEST_BITS - 4'h1) begin
               st_nxt = ST_IDLE;
            end
         end
         default: begin
            st_nxt = ST_IDLE;
         end
      endcase
   end

   // Delay counter in clocks and duration counter in bit cells
   // Counting clocks rather than cells keeps the minimum delay exact
   always @(posedge clock) begin
      if (rst) begin
         dly_r <= 6'h00;
         bits_r <= 4'h0;
      end else begin
         if (st_r == ST_WAIT) begin
            dly_r <= dly_r + 6'h01;
         end else begin
            dly_r <= 6'h00;
         end
         if (!test_on) begin
            bits_r <= 4'h0;
         end else if (bit_en) begin
            bits_r <= bits_r + 4'h1;
         end
      end
   end

   // Collision indication and its realisation on control-in; the medium
   // detector already refuses a single transmitter, so it is used as is.
   // Path is two clocks, far inside nine bit cells, and removal is as fast.
   always @(posedge clock) begin
      if (rst) begin
         collision_r <= 1'b0;
         ci_sym_r <= `CMAU_SYM_IDL;
      end else begin
         collision_r <= col_now;
         if (collision_r) begin
            ci_sym_r <= `CMAU_SYM_CSO;
         end else begin
            ci_sym_r <= `CMAU_SYM_IDL;
         end
      end
   end

   // Event counters; a write clears, but an event in the same cycle still counts
   always @(posedge clock) begin
      if (rst) begin
         col_prev_r <= 1'b0;
         colcnt_r <= 16'h0000;
         frmcnt_r <= 16'h0000;
      end else begin
         col_prev_r <= collision_r;
         colcnt_r <= colcnt_nxt;
         frmcnt_r <= frmcnt_nxt;
      end
   end

   // Control register: isolate support and post-frame test enable
   // Test enable resets on, so a station that never writes still runs the test
   always @(posedge clock) begin
      if (rst) begin
         ctrl_r <= `CMAU_CTRL_RST;
      end else if (wr_ctrl) begin
         ctrl_r <= wb_dat_i[1:0];
      end
   end

   // Read mux; unmapped addresses read as zero
   // Status shows live levels; two reads with no write between may differ
   always @* begin
      rdata = 32'h00000000;
      case (wb_adr_i)
         `CMAU_ADR_CTRL: begin
            rdata[1:0] = ctrl_r;
         end
         `CMAU_ADR_STAT: begin
            rdata[`CMAU_STAT_COL] = collision_r;
            rdata[`CMAU_STAT_JAB] = jab;
            rdata[`CMAU_STAT_ISO] = isolated_r;
            rdata[`CMAU_STAT_TX] = tx_now;
            rdata[`CMAU_STAT_TEST] = test_on;
            rdata[`CMAU_STAT_DRV] = drv_en_r;
         end
         `CMAU_ADR_COLCNT: begin
            rdata[15:0] = colcnt_r;
         end
         `CMAU_ADR_FRMCNT: begin
            rdata[15:0] = frmcnt_r;
         end
         default: begin
            rdata = 32'h00000000;
         end
      endcase
   end

   // Wishbone classic: ack one cycle after the strobe, every address answers
   // Read data holds between reads, so a late sample still sees the word
   always @(posedge clock) begin
      if (rst) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h00000000;
      end else begin
         wb_ack_o <= wb_req;
         if (wb_req && !wb_we_i) begin
            wb_dat_o <= rdata;
         end
      end
   end

endmodule

//--- verif/cmau_dte_model.sv
`timescale 1ns/1ps
`include "cmau_consts.vh"

module cmau_dte_model (
   input wire clock,
   output logic [1:0] do_sym,
   output logic [1:0] co_sym
);
   // Idle on both circuits from time zero
   initial begin
      do_sym = `CMAU_SYM_IDL;
      co_sym = `CMAU_SYM_IDL;
   end

   // Five clocks per symbol so the 2/3 bit divider always samples each one
   task automatic send_frame(input int nbits);
      for (int i = 0; i < nbits; i++) begin
         do_sym <= i[0] ? `CMAU_SYM_CD1 : `CMAU_SYM_CD0;
         repeat (5) @(posedge clock);
      end
      do_sym <= `CMAU_SYM_IDL;
   endtask

   // Control-out: IDL for normal, CSO for the isolate request
   task automatic set_ctl(input logic [1:0] s);
      co_sym <= s;
   endtask
endmodule

//--- verif/cmau_top_asserts.sv
`timescale 1ns/1ps
`include "cmau_consts.vh"

module cmau_top_asserts (
   input wire clock,
   input wire rst,
   input wire wb_cyc_i,
   input wire wb_stb_i,
   input wire wb_ack_o,
   input wire [1:0] rx_sym,
   input wire medium_multi,
   input wire [1:0] di_sym_r,
   input wire [1:0] ci_sym_r,
   input wire [1:0] tx_sym_r,
   input wire drv_en_r,
   input wire pos_dis_r,
   input wire collision_r
);
   // Two clean edges after reset first, so no history from reset is judged
   logic [1:0] up_r;
   always @(posedge clock) begin
      up_r <= rst ? 2'h0 : {up_r[0], 1'b1};
   end
   default clocking cb_main @(posedge clock);
   endclocking
   default disable iff (rst || !up_r[1]);

   chk_di_follow: assert property (di_sym_r == $past(rx_sym))
      else $error("data-in does not follow the receive symbol");
   chk_col_cause: assert property (medium_multi |=> collision_r)
      else $error("collision missed");
   chk_sqe_cso: assert property (collision_r |=> ci_sym_r == `CMAU_SYM_CSO)
      else $error("no CSO during collision");
   chk_avail_idle: assert property (!collision_r |=> ci_sym_r == `CMAU_SYM_IDL)
      else $error("control-in not idle");
   chk_sqe_onset: assert property ($rose(medium_multi) |-> ##2 ci_sym_r == `CMAU_SYM_CSO)
      else $error("error indication late");
   chk_drv_gate: assert property (!drv_en_r |-> tx_sym_r == `CMAU_SYM_IDL)
      else $error("data sent with driver off");
   chk_pos_dis: assert property (pos_dis_r |-> !drv_en_r)
      else $error("driver on while disabled");
   chk_ack_req: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("bus request not answered");
   chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
endmodule

bind cmau_top cmau_top_asserts cmau_top_asserts_i (
   .clock(clock), .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
   .wb_ack_o(wb_ack_o), .rx_sym(rx_sym), .medium_multi(medium_multi),
   .di_sym_r(di_sym_r), .ci_sym_r(ci_sym_r), .tx_sym_r(tx_sym_r),
   .drv_en_r(drv_en_r), .pos_dis_r(pos_dis_r), .collision_r(collision_r)
);

//--- verif/tb.sv
`timescale 1ns/1ps
`include "cmau_consts.vh"

module tb;
   typedef struct packed {
      logic [1:0] rx;
      logic mm;
      logic [1:0] ci;
   } cmau_row_t;
   logic clock = 1'b0;
   logic rst = 1'b1;
   logic wb_cyc = 1'b0;
   logic wb_stb = 1'b0;
   logic wb_we = 1'b0;
   logic [3:0] wb_adr = 4'h0;
   logic [31:0] wb_wd = 32'h0;
   logic [3:0] wb_sel = 4'hf;
   logic [31:0] wb_rd, rd;
   logic wb_ack, drv_en, pos_dis, collision, medium_multi = 1'b0;
   logic [1:0] do_sym, co_sym, di_sym, ci_sym, tx_sym, rx_sym = `CMAU_SYM_IDL;
   int failures = 0;
   int n_checks = 0;
   int cyc_cnt = 0;
   int n, ncol;
   cmau_row_t rows [7] = '{
      '{`CMAU_SYM_IDL, 1'b0, `CMAU_SYM_IDL}, '{`CMAU_SYM_CD0, 1'b0, `CMAU_SYM_IDL},
      '{`CMAU_SYM_CD1, 1'b0, `CMAU_SYM_IDL}, '{`CMAU_SYM_CD1, 1'b1, `CMAU_SYM_CSO},
      '{`CMAU_SYM_CD0, 1'b0, `CMAU_SYM_IDL}, '{`CMAU_SYM_IDL, 1'b1, `CMAU_SYM_CSO},
      '{`CMAU_SYM_IDL, 1'b0, `CMAU_SYM_IDL}};

   // Short counts so the jabber window and its release fit the run
   cmau_top #(.JAB_CYC(24'h0000c8), .UNJAB_CYC(24'h00012c)) cmau_top_i (
      .clock(clock), .rst(rst), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
      .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_wd), .wb_dat_o(wb_rd),
      .wb_ack_o(wb_ack), .do_sym(do_sym), .co_sym(co_sym), .di_sym_r(di_sym),
      .ci_sym_r(ci_sym), .rx_sym(rx_sym), .medium_multi(medium_multi), .tx_sym_r(tx_sym),
      .drv_en_r(drv_en), .pos_dis_r(pos_dis), .collision_r(collision));
   cmau_dte_model cmau_dte_model_i (.clock(clock), .do_sym(do_sym), .co_sym(co_sym));

   always #20 clock = ~clock;

   // Hang guard, far above the roughly 1200 cycles the sequence needs
   always @(posedge clock) begin
      cyc_cnt++;
      if (cyc_cnt == 20000) begin
         failures++;
         final_report();
      end
   end

   task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
      n_checks++;
      if (got !== exp) begin
         failures++;
         $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask

   // Classic cycle; called at a rising edge, waits for ack with no assumed latency
   task automatic wb(input logic we, input logic [3:0] adr, input logic [31:0] wd);
      wb_cyc <= 1'b1;
      wb_stb <= 1'b1;
      wb_we <= we;
      wb_adr <= adr;
      wb_wd <= wd;
      @(posedge clock);
      while (wb_ack !== 1'b1) @(posedge clock);
      rd = wb_rd;
      wb_cyc <= 1'b0;
      wb_stb <= 1'b0;
      @(posedge clock);
   endtask

   task automatic wait_col(input logic lvl);
      n = 0;
      while (collision !== lvl && n < 80) begin
         @(posedge clock);
         n++;
      end
   endtask

   task automatic final_report();
      $display("checks %0d failures %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   initial begin
      repeat (5) @(posedge clock);
      rst <= 1'b0;
      @(posedge clock);
      check({drv_en, pos_dis, collision, ci_sym, tx_sym}, 7'h00, "reset outputs");
      wb(1'b0, `CMAU_ADR_CTRL, 32'h0);
      check(rd, `CMAU_CTRL_RST, "ctrl reset");
      wb(1'b0, 4'h2, 32'h0);
      check(rd, 32'h0, "unmapped read");
      wb(1'b1, `CMAU_ADR_STAT, 32'hffffffff);
      wb(1'b0, `CMAU_ADR_STAT, 32'h0);
      check(rd[5:0], 6'h00, "status read-only");
      // A control write with its byte lane off leaves the register alone
      wb_sel <= 4'h0;
      wb(1'b1, `CMAU_ADR_CTRL, 32'h1);
      wb_sel <= 4'hf;
      wb(1'b0, `CMAU_ADR_CTRL, 32'h0);
      check(rd, `CMAU_CTRL_RST, "ctrl lane off");
      // Receive and collision table; the count of rising collisions is kept aside
      ncol = 0;
      foreach (rows[i]) begin
         rx_sym <= rows[i].rx;
         medium_multi <= rows[i].mm;
         if (rows[i].mm && (i == 0 || !rows[i - 1].mm)) ncol++;
         repeat (3) @(posedge clock);
         check(di_sym, rows[i].rx, "data in");
         check(ci_sym, rows[i].ci, "control in");
      end
      wb(1'b0, `CMAU_ADR_COLCNT, 32'h0);
      check(rd[15:0], ncol, "collision count");
      // Own frame, then the post-frame test at 15..40 clocks lasting 5..15 bit cells
      fork
         cmau_dte_model_i.send_frame(8);
         begin
            repeat (20) @(posedge clock);
            check({drv_en, collision, tx_sym == `CMAU_SYM_IDL}, 3'h4, "driving");
         end
      join
      wait_col(1'b1);
      check(n >= 15 && n <= 40, 1'b1, "test delay");
      wait_col(1'b0);
      check(n >= 12 && n <= 38, 1'b1, "test width");
      wb(1'b0, `CMAU_ADR_FRMCNT, 32'h0);
      check(rd[15:0], 16'h0001, "frame count");
      // Frame longer than the window: inhibit with error indication, later release
      fork
         cmau_dte_model_i.send_frame(60);
         begin
            repeat (100) @(posedge clock);
            check(drv_en, 1'b1, "inside window");
            repeat (150) @(posedge clock);
            check({drv_en, collision, ci_sym}, {2'h1, `CMAU_SYM_CSO}, "jabber");
            wb(1'b0, `CMAU_ADR_STAT, 32'h0);
            check(rd[`CMAU_STAT_JAB], 1'b1, "jabber status");
         end
      join
      repeat (450) @(posedge clock);
      check(collision, 1'b0, "jabber released");
      // Isolate ignored until enabled; while isolated, receive still flows
      cmau_dte_model_i.set_ctl(`CMAU_SYM_CSO);
      repeat (10) @(posedge clock);
      check(pos_dis, 1'b0, "isolate refused");
      wb(1'b1, `CMAU_ADR_CTRL, 32'h3);
      repeat (10) @(posedge clock);
      check({pos_dis, drv_en}, 2'h2, "isolated");
      rx_sym <= `CMAU_SYM_CD1;
      fork
         cmau_dte_model_i.send_frame(8);
         begin
            repeat (20) @(posedge clock);
            check({drv_en, di_sym}, {1'b0, `CMAU_SYM_CD1}, "isolated frame");
         end
      join
      repeat (80) @(posedge clock);
      cmau_dte_model_i.set_ctl(`CMAU_SYM_IDL);
      repeat (10) @(posedge clock);
      check(pos_dis, 1'b0, "normal");
      // Post-frame test switched off: a finished frame leaves control-in idle
      wb(1'b1, `CMAU_ADR_CTRL, 32'h0);
      cmau_dte_model_i.send_frame(8);
      wait_col(1'b1);
      check(collision, 1'b0, "test disabled");
      // Mid-run reset: outputs and control return to their reset values
      rst <= 1'b1;
      repeat (2) @(posedge clock);
      rst <= 1'b0;
      @(posedge clock);
      check({drv_en, pos_dis, collision, ci_sym, tx_sym}, 7'h00, "second reset");
      wb(1'b0, `CMAU_ADR_CTRL, 32'h0);
      check(rd, `CMAU_CTRL_RST, "ctrl after reset");
      final_report();
   end
endmodule
